// ---- bench/flash_cmd_host_checker.sv ----
// concurrent checks on the host flash sequencer ports
// assumes a bind onto flash_cmd_host, one clock, sync active-low reset
`timescale 1ns/1ps
module flash_cmd_host_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // user side
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        rd_valid,
  // flash pins
  input wire logic [23:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic        flash_dq_oe,
  input wire logic        flash_ce_n,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_write_frame: assert property (
    !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
    else $error("write strobe outside a driven select");
  a_read_frame: assert property (
    !flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe)
    else $error("read strobe with data pins driven");
  a_upper_quiet: assert property (
    flash_dq_oe |-> flash_dq_out[15:8] == 8'h00)
    else $error("upper byte driven nonzero");
  a_pulse_width: assert property (
    $fell(flash_we_n) |-> !flash_we_n [*3])
    else $error("write pulse too short");
  // address and data must not move inside the pulse, the device latches on both ends
  a_addr_steady: assert property (
    !flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("pins moved inside write pulse");
  a_data_hold: assert property (
    $rose(flash_we_n) |-> $stable(flash_addr) && flash_dq_oe)
    else $error("no hold after write pulse");
  a_read_done: assert property (
    $rose(flash_oe_n) |-> ##[0:3] rd_valid)
    else $error("read ended without result");
  a_one_pulse: assert property (
    rd_valid |=> !rd_valid)
    else $error("result pulse too long");
  a_busy_after: assert property (
    cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("not busy after taking a command");
endmodule // flash_cmd_host_checker

// ---- bench/flash_cmd_host_test.sv ----
// bench for the host flash sequencer against a behavioural flash model
// assumes the model logs each write cycle it sees on the pins
`timescale 1ns/1ps
module flash_cmd_host_test;
  import flash_cmd_pkg::*;
  typedef logic [31:0] seq_t [6];
  localparam logic [23:0] XA = 24'hFFFFFF; // address not compared
  localparam logic [23:0] SECT = 24'h370000;
  localparam logic [31:0] UA = {ADDR_UNLOCK1, D_UNLOCK1};
  localparam logic [31:0] UB = {ADDR_UNLOCK2, D_UNLOCK2};
  localparam logic [31:0] IDS = 32'h3D6B5219; // arbitrary
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cmd_valid = 1'b0;
  cmd_s        cmd = '0;
  logic        buf_we = 1'b0;
  logic [5:0]  buf_waddr = '0;
  logic [31:0] buf_wdata = '0;
  logic        cmd_ready, rd_valid, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  logic [7:0]  rd_data;
  logic [23:0] flash_addr;
  logic [15:0] flash_dq_out;
  wire  [15:0] flash_dq_in;
  int          fails = 0;
  int          samples_checked = 0;
  int          base;
  int          rd_pulses = 0;
  always #10 clk = ~clk;
  // rd_valid stands one cycle, so each pulse is seen at exactly one edge
  always @(posedge clk) if (rd_valid === 1'b1) rd_pulses++;
  flash_cmd_host u_flash_cmd_host (.clk, .resetn, .cmd_valid, .cmd_ready, .cmd, .buf_we,
    .buf_waddr, .buf_wdata, .rd_valid, .rd_data, .flash_addr, .flash_dq_out, .flash_dq_oe,
    .flash_dq_in, .flash_ce_n, .flash_we_n, .flash_oe_n);
  flash_dev_model #(.MFR_ID(IDS[31:24]), .DEV_ID1(IDS[23:16]), .DEV_ID2(IDS[15:8]),
    .DEV_ID3(IDS[7:0])) u_flash_dev_model (.flash_addr, .flash_dq_out, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .flash_dq_in);
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hold;
    int i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (cmd_ready !== 1'b1 && i < 2000);
    if (cmd_ready !== 1'b1) begin
      fails++;
      give_verdict;
    end
  endtask
  // c below zero compares the first -c writes and skips the write count
  task automatic run(op_e op, logic [23:0] a, logic [7:0] d, logic [7:0] x, int c, seq_t e);
    logic [31:0] g;
    hold;
    base = u_flash_dev_model.n;
    cmd_valid = 1'b1;
    cmd = '{op, a, d, x};
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    hold;
    for (int k = 0; k < (c < 0 ? -c : c); k++) begin
      g = {u_flash_dev_model.la[base + k], u_flash_dev_model.ld[base + k]};
      if (e[k][31:8] == XA) g[31:8] = XA;
      cmp(g, e[k]);
    end
    if (c >= 0) cmp(32'(u_flash_dev_model.n - base), 32'(c));
  endtask
  task automatic t_read(logic [23:0] a);
    int p;
    p = rd_pulses;
    run(OP_READ, a, 8'h00, 8'h00, 0, '{6{32'h0}});
    cmp(32'(rd_data), 32'(a[7:0] ^ a[15:8] ^ 8'h3C));
    cmp(32'(rd_pulses - p), 32'd1);
  endtask
  task automatic t_autosel;
    logic [23:0] ao [7] = '{0, 0, 0, 0, SECT, 24'h120000, 0};
    logic [7:0] of [7] = '{OFS_MFR, OFS_DEV1, OFS_DEV2, OFS_DEV3, OFS_PROT, OFS_PROT, OFS_SEC};
    logic [7:0] ex [7] = '{IDS[31:24], IDS[23:16], IDS[15:8], IDS[7:0], 8'h01, 8'h00, 8'h80};
    for (int i = 0; i < 7; i++) begin
      run(OP_AUTOSEL, ao[i], 0, of[i], 3, '{UA, UB, {ADDR_UNLOCK1, D_AUTOSEL}, 0, 0, 0});
      cmp(32'(rd_data), 32'(ex[i]));
      run(OP_RESET, 0, 0, 0, 1, '{{XA, D_RESET}, 0, 0, 0, 0, 0});
    end
    t_read(24'h00A5C3);
  endtask
  task automatic t_program;
    run(OP_PROGRAM, 24'h345678, 8'h5A, 0, 4,
      '{UA, UB, {ADDR_UNLOCK1, D_PROGRAM}, {24'h345678, 8'h5A}, 0, 0});
    run(OP_QUERY, 0, 0, 0, 1, '{{ADDR_QUERY, D_QUERY}, 0, 0, 0, 0, 0});
  endtask
  task automatic t_buffer;
    @(posedge clk);
    #1;
    buf_we = 1'b1;
    buf_wdata = {SECT | 24'h10, 8'h11};
    @(posedge clk);
    #1;
    buf_waddr = 6'h01;
    buf_wdata = {SECT | 24'h11, 8'h22};
    @(posedge clk);
    #1;
    buf_we = 1'b0;
    run(OP_BUF_LOAD, SECT, 8'h01, 0, 6, '{UA, UB, {SECT, D_BUFLOAD}, {SECT, 8'h01},
      {SECT | 24'h10, 8'h11}, {SECT | 24'h11, 8'h22}});
    run(OP_BUF_CONFIRM, SECT, 0, 0, 1, '{{SECT, D_CONFIRM}, 0, 0, 0, 0, 0});
    run(OP_ABORT_RESET, 0, 0, 0, 3, '{UA, UB, {ADDR_UNLOCK1, D_RESET}, 0, 0, 0});
  endtask
  task automatic t_bypass;
    run(OP_BYPASS_ENTER, 0, 0, 0, 3, '{UA, UB, {ADDR_UNLOCK1, D_BYPASS}, 0, 0, 0});
    run(OP_BYPASS_PROG, 24'h371234, 8'h3C, 0, 2,
      '{{XA, D_PROGRAM}, {24'h371234, 8'h3C}, 0, 0, 0, 0});
    run(OP_BYPASS_SERASE, SECT, 0, 0, 2, '{{XA, D_ERASE}, {SECT, D_SECTOR}, 0, 0, 0, 0});
    run(OP_BYPASS_CERASE, 0, 0, 0, 2, '{{XA, D_ERASE}, {XA, D_CHIP}, 0, 0, 0, 0});
    run(OP_BYPASS_EXIT, 0, 0, 0, 2, '{{XA, D_AUTOSEL}, {XA, D_EXIT}, 0, 0, 0, 0});
  endtask
  task automatic t_erase;
    run(OP_CHIP_ERASE, 0, 0, 0, 6,
      '{UA, UB, {ADDR_UNLOCK1, D_ERASE}, UA, UB, {ADDR_UNLOCK1, D_CHIP}});
    run(OP_SECTOR_ERASE, SECT, 0, 0, 6,
      '{UA, UB, {ADDR_UNLOCK1, D_ERASE}, UA, UB, {SECT, D_SECTOR}});
    run(OP_SUSPEND, 0, 0, 0, 1, '{{XA, D_SUSPEND}, 0, 0, 0, 0, 0});
    run(OP_RESET, 0, 0, 8'h01, 1, '{{XA, D_RESUME}, 0, 0, 0, 0, 0});
  endtask
  task automatic t_secure;
    run(OP_BYPASS_ENTER, 0, 0, 8'h01, 3, '{UA, UB, {ADDR_UNLOCK1, D_SECURE}, 0, 0, 0});
    run(OP_SECTOR_ERASE, 0, 0, 8'h01, 4,
      '{UA, UB, {ADDR_UNLOCK1, D_AUTOSEL}, {XA, D_EXIT}, 0, 0});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_read(24'h12A4C6);
    t_autosel;
    t_program;
    t_buffer;
    t_bypass;
    t_erase;
    t_secure;
    give_verdict;
  end
endmodule // flash_cmd_host_test
bind flash_cmd_host flash_cmd_host_checker u_flash_cmd_host_checker (.clk, .resetn, .cmd_valid,
  .cmd_ready, .rd_valid, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n,
  .flash_oe_n);

// ---- bench/flash_dev_model.sv ----
// behavioural x8 flash: logs write cycles, answers array and id reads
// assumes host-driven strobes; array reads return an address pattern
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [7:0] MFR_ID    = 8'h3D, // arbitrary
  parameter logic [7:0] DEV_ID1   = 8'h6B, // arbitrary
  parameter logic [7:0] DEV_ID2   = 8'h52, // arbitrary
  parameter logic [7:0] DEV_ID3   = 8'h19, // arbitrary
  parameter logic [7:0] PROT_SECT = 8'h37,
  parameter int         RD_DLY    = 25
) (
  // host pins
  input  wire logic [23:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  // device drive
  output wire logic [15:0] flash_dq_in
);
  logic [23:0] la [256];
  logic [7:0]  ld [256];
  logic [23:0] lat;
  logic [7:0]  rv;
  logic [7:0]  last = 8'h00;
  logic        idm = 1'b0;
  int          n = 0;
  wire         wr_act = !flash_ce_n && !flash_we_n;
  wire         rd_act = !flash_ce_n && !flash_oe_n;
  always @(posedge wr_act) lat = flash_addr;
  // the power-up fall from x is not a write, so nothing is latched yet
  always @(negedge wr_act) begin
    if (!$isunknown(lat)) begin
      la[n] = lat;
      ld[n] = flash_dq_out[7:0];
      if (ld[n] == 8'hF0) idm = 1'b0;
      // only a 90 two writes after an AA enters the mode, an F0 leaves it
      else if (n > 1 && ld[n] == 8'h90 && ld[n-2] == 8'hAA)
        idm = 1'b1;
      n++;
    end
  end
  always_comb begin
    rv = flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h3C;
    if (idm) begin
      case (flash_addr[7:0])
        8'h00: rv = MFR_ID;
        8'h02: rv = DEV_ID1;
        8'h1C: rv = DEV_ID2;
        8'h1E: rv = DEV_ID3;
        8'h04: rv = {7'h00, flash_addr[23:16] == PROT_SECT};
        8'h06: rv = 8'h80;
        default: rv = 8'h00;
      endcase
    end
  end
  always @(rv or rd_act) if (rd_act) last = rv;
  // released pins show the inverse of the last byte, so a stale sample is caught
  assign #(RD_DLY) flash_dq_in = rd_act ? {~rv, rv} : {8'hFF, ~last};
endmodule // flash_dev_model

// ---- logic/flash_buf_mem.sv ----
// small word store for the write-buffer payload
// assumes one writer and one reader on the host clock
`timescale 1ns/1ps
module flash_buf_mem (
  // clock
  input  wire logic        clk,
  // write side
  input  wire logic        we,
  input  wire logic [5:0]  waddr,
  input  wire logic [31:0] wdata,
  // read side
  input  wire logic [5:0]  raddr,
  output logic      [31:0] rdata
);
  logic [31:0] mem [0:63];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // flash_buf_mem

// ---- logic/flash_cmd_host.sv ----
// host sequencer: turns one user command into flash bus cycles
// assumes the flash pins are registered here and the device is idle when a command starts
`timescale 1ns/1ps
module flash_cmd_host (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // user command
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire flash_cmd_pkg::cmd_s        cmd,
  // buffer payload, written before OP_BUF_LOAD
  input  wire logic                       buf_we,
  input  wire logic [5:0]                 buf_waddr,
  input  wire logic [31:0]                buf_wdata,
  // result
  output logic                            rd_valid,
  output logic [7:0]                      rd_data,
  // flash pins
  output logic [flash_cmd_pkg::AW-1:0]    flash_addr,
  output logic [15:0]                     flash_dq_out,
  output logic                            flash_dq_oe,
  input  wire logic [15:0]                flash_dq_in,
  output logic                            flash_ce_n,
  output logic                            flash_we_n,
  output logic                            flash_oe_n
);
  import flash_cmd_pkg::*;

  typedef enum {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_NEXT} state_e;
  state_e        state_reg;
  cmd_s          cmd_reg;
  logic [6:0]    idx_reg;
  logic [6:0]    total_reg;
  logic [3:0]    cnt_reg;
  logic [7:0]    dq_s1_reg;
  logic [7:0]    dq_s2_reg;
  logic [7:0]    dq_s3_reg;
  logic [5:0]    buf_raddr;
  logic [31:0]   buf_rdata;
  cyc_s          cur;

  function automatic cyc_s wcyc(input logic [AW-1:0] a, input logic [7:0] d);
    wcyc.wr = 1'b1;
    wcyc.addr = a;
    wcyc.data = d;
  endfunction
  function automatic cyc_s rcyc(input logic [AW-1:0] a);
    rcyc.wr = 1'b0;
    rcyc.addr = a;
    rcyc.data = 8'h00;
  endfunction

  // cycles per command; buffer load is 5 plus the count field (word count minus one), so 4 plus word count pairs
  function automatic logic [6:0] op_len(input cmd_s c);
    case (c.op)
      OP_READ, OP_RESET, OP_QUERY, OP_BUF_CONFIRM, OP_SUSPEND: op_len = 7'd1;
      OP_BYPASS_PROG, OP_BYPASS_SERASE, OP_BYPASS_CERASE, OP_BYPASS_EXIT: op_len = 7'd2;
      OP_ABORT_RESET, OP_BYPASS_ENTER: op_len = 7'd3;
      OP_AUTOSEL, OP_PROGRAM: op_len = 7'd4;
      OP_BUF_LOAD: op_len = 7'(c.data[5:0]) + 7'd5;
      // secured exit is only four writes; a trailing unlock would open a stray sequence
      default: op_len = (c.op == OP_SECTOR_ERASE && c.aux[0]) ? 7'd4 : 7'd6;
    endcase
  endfunction

  logic [AW-1:0] sect;
  assign sect = cmd_reg.addr & SECTOR_MASK;
  // the store answers a cycle late, so its address runs one slot ahead of idx_reg
  assign buf_raddr = 6'(idx_reg - 7'd3);

  // aux selects variants: autoselect offset, secured entry/exit, resume
  always_comb begin
    cur = wcyc(ADDR_UNLOCK1, D_UNLOCK1);
    if (idx_reg == 7'd1) begin
      cur = wcyc(ADDR_UNLOCK2, D_UNLOCK2);
    end
    case (cmd_reg.op)
      OP_READ: cur = rcyc(cmd_reg.addr);
      OP_RESET: cur = (cmd_reg.aux[0]) ? wcyc(ADDR_ANY, D_RESUME)
                                       : wcyc(ADDR_ANY, D_RESET);
      OP_SUSPEND: cur = wcyc(ADDR_ANY, D_SUSPEND);
      OP_QUERY: cur = wcyc(ADDR_QUERY, D_QUERY);
      OP_AUTOSEL: begin
        if (idx_reg == 7'd2) begin
          cur = wcyc(ADDR_UNLOCK1, D_AUTOSEL);
        end else if (idx_reg == 7'd3) begin
          // offset X04 combines with the sector bits
          cur = rcyc((cmd_reg.aux == OFS_PROT) ? (sect | AW'(OFS_PROT)) : AW'(cmd_reg.aux));
        end
      end
      OP_PROGRAM: begin
        if (idx_reg == 7'd2) begin
          cur = wcyc(ADDR_UNLOCK1, D_PROGRAM);
        end else if (idx_reg == 7'd3) begin
          cur = wcyc(cmd_reg.addr, cmd_reg.data);
        end
      end
      OP_BUF_LOAD: begin
        if (idx_reg == 7'd2) begin
          cur = wcyc(sect, D_BUFLOAD);
        end else if (idx_reg == 7'd3) begin
          cur = wcyc(sect, cmd_reg.data);
        end else if (idx_reg >= 7'd4) begin
          cur = wcyc(buf_rdata[AW+7:8], buf_rdata[7:0]);
        end
      end
      OP_BUF_CONFIRM: cur = wcyc(sect, D_CONFIRM);
      OP_ABORT_RESET: begin
        if (idx_reg == 7'd2) begin
          cur = wcyc(ADDR_UNLOCK1, D_RESET);
        end
      end
      OP_BYPASS_ENTER: begin
        if (idx_reg == 7'd2) begin
          cur = wcyc(ADDR_UNLOCK1, (cmd_reg.aux[0]) ? D_SECURE : D_BYPASS);
        end
      end
      OP_BYPASS_PROG: cur = (idx_reg == 7'd0) ? wcyc(ADDR_ANY, D_PROGRAM)
                                              : wcyc(cmd_reg.addr, cmd_reg.data);
      OP_BYPASS_SERASE: cur = (idx_reg == 7'd0) ? wcyc(ADDR_ANY, D_ERASE)
                                                : wcyc(sect, D_SECTOR);
      OP_BYPASS_CERASE: cur = (idx_reg == 7'd0) ? wcyc(ADDR_ANY, D_ERASE)
                                                : wcyc(ADDR_ANY, D_CHIP);
      OP_BYPASS_EXIT: cur = (idx_reg == 7'd0) ? wcyc(ADDR_ANY, D_AUTOSEL)
                                              : wcyc(ADDR_ANY, D_EXIT);
      default: begin
        // erase, or secured exit when sector erase has aux[0]
        if (cmd_reg.aux[0] && cmd_reg.op == OP_SECTOR_ERASE) begin
          if (idx_reg == 7'd2) begin
            cur = wcyc(ADDR_UNLOCK1, D_AUTOSEL);
          end else if (idx_reg == 7'd3) begin
            cur = wcyc(ADDR_ANY, D_EXIT);
          end
        end else if (idx_reg == 7'd2) begin
          cur = wcyc(ADDR_UNLOCK1, D_ERASE);
        end else if (idx_reg == 7'd4) begin
          cur = wcyc(ADDR_UNLOCK2, D_UNLOCK2);
        end else if (idx_reg == 7'd5) begin
          cur = (cmd_reg.op == OP_CHIP_ERASE) ? wcyc(ADDR_UNLOCK1, D_CHIP)
                                              : wcyc(sect, D_SECTOR);
        end
      end
    endcase
  end

  assign cmd_ready = (state_reg == S_IDLE);

  flash_buf_mem u_buf (
    .clk   (clk),
    .we    (buf_we),
    .waddr (buf_waddr),
    .wdata (buf_wdata),
    .raddr (buf_raddr),
    .rdata (buf_rdata)
  );

  // three-stage sampling of the asynchronous data pins
  always_ff @(posedge clk) begin
    dq_s1_reg <= flash_dq_in[7:0];
    dq_s2_reg <= dq_s1_reg;
    dq_s3_reg <= dq_s2_reg;
  end

  logic dq_stable;
  assign dq_stable = (dq_s2_reg == dq_s3_reg);

  // we_n and ce_n fall together after address setup and rise together,
  // so both edge orders of the latch coincide
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg    <= S_IDLE;
      cmd_reg      <= '0;
      idx_reg      <= '0;
      total_reg    <= '0;
      cnt_reg      <= '0;
      rd_valid     <= 1'b0;
      rd_data      <= '0;
      flash_addr   <= '0;
      flash_dq_out <= '0;
      flash_dq_oe  <= 1'b0;
      flash_ce_n   <= 1'b1;
      flash_we_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
    end else begin
      rd_valid <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (cmd_valid) begin
            cmd_reg   <= cmd;
            total_reg <= op_len(cmd);
            idx_reg   <= '0;
            state_reg <= S_NEXT;
          end
        end
        S_NEXT: begin
          // upper byte driven zero, top bits only from sector, read, program or buffer payload address
          flash_addr   <= cur.addr;
          flash_dq_out <= {8'h00, cur.data};
          flash_dq_oe  <= cur.wr;
          flash_ce_n   <= 1'b1;
          cnt_reg      <= SETUP_CYC;
          state_reg    <= S_SETUP;
        end
        S_SETUP: begin
          if (cnt_reg <= 4'd1) begin
            flash_ce_n <= 1'b0;
            flash_we_n <= ~cur.wr;
            flash_oe_n <= cur.wr;
            cnt_reg    <= PULSE_CYC + HOLD_CYC;
            state_reg  <= S_PULSE;
          end else begin
            cnt_reg <= cnt_reg - 4'd1;
          end
        end
        S_PULSE: begin
          if (cnt_reg <= 4'd1 && (cur.wr || dq_stable)) begin
            if (!cur.wr) begin
              rd_valid <= 1'b1;
              rd_data  <= dq_s3_reg;
            end
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            cnt_reg    <= HOLD_CYC;
            state_reg  <= S_HOLD;
          end else if (cnt_reg > 4'd1) begin
            cnt_reg <= cnt_reg - 4'd1;
          end
        end
        default: begin
          if (cnt_reg <= 4'd1) begin
            flash_dq_oe <= 1'b0;
            idx_reg     <= idx_reg + 7'd1;
            state_reg   <= (idx_reg + 7'd1 >= total_reg) ? S_IDLE : S_NEXT;
          end else begin
            cnt_reg <= cnt_reg - 4'd1;
          end
        end
      endcase
    end
  end
endmodule // flash_cmd_host

// ---- logic/flash_cmd_pkg.sv ----
// constants and carrier types for the host-side flash command sequencer
// assumes an x8 parallel nor flash on an asynchronous bus, one 50 MHz host clock
// Functional notes
// - every cycle is a write unless that cycle is defined as a read.
// - autoselect is AA@AAA, 55@555, 90@AAA; further cycles are reads.
// - word program is AA@AAA, 55@555, A0@AAA, then data at program address.
// - buffer load is unlock, 25@sector, then word count minus one at sector.
// - host writes one address-data pair per slot in the same buffer page.
// - 29 at the sector address starts programming the loaded buffer.
// - bypass entry is unlock plus 20; then A0 program, 80/30 or 80/10 erase.
// - erase is six writes ending 10@AAA for chip or 30@sector for sector.
// - secured region entry is AA@AAA, 55@555, 88@AAA.
package flash_cmd_pkg;
  localparam int AW = 24;
  localparam logic [AW-1:0] ADDR_UNLOCK1 = 24'h000AAA;
  localparam logic [AW-1:0] ADDR_UNLOCK2 = 24'h000555;
  localparam logic [AW-1:0] ADDR_QUERY   = 24'h0000AA;
  localparam logic [AW-1:0] ADDR_ANY     = 24'h000000;
  localparam logic [7:0] OFS_MFR  = 8'h00;
  localparam logic [7:0] OFS_DEV1 = 8'h02;
  localparam logic [7:0] OFS_PROT = 8'h04;
  localparam logic [7:0] OFS_SEC  = 8'h06;
  localparam logic [7:0] OFS_DEV2 = 8'h1C;
  localparam logic [7:0] OFS_DEV3 = 8'h1E;
  localparam logic [7:0] D_UNLOCK1 = 8'hAA;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_RESET   = 8'hF0;
  localparam logic [7:0] D_AUTOSEL = 8'h90;
  localparam logic [7:0] D_QUERY   = 8'h98;
  localparam logic [7:0] D_PROGRAM = 8'hA0;
  localparam logic [7:0] D_BUFLOAD = 8'h25;
  localparam logic [7:0] D_CONFIRM = 8'h29;
  localparam logic [7:0] D_BYPASS  = 8'h20;
  localparam logic [7:0] D_ERASE   = 8'h80;
  localparam logic [7:0] D_CHIP    = 8'h10;
  localparam logic [7:0] D_SECTOR  = 8'h30;
  localparam logic [7:0] D_SUSPEND = 8'hB0;
  localparam logic [7:0] D_RESUME  = 8'h30;
  localparam logic [7:0] D_SECURE  = 8'h88;
  localparam logic [7:0] D_EXIT    = 8'h00;
  localparam logic [AW-1:0] SECTOR_MASK = 24'hFF0000;
  // strobe timing in ns and derived 50 MHz cycles
  localparam int CLK_NS   = 20;
  localparam int T_SETUP_NS = 40;
  localparam int T_PULSE_NS = 60;
  localparam int T_HOLD_NS  = 40;
  localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC  = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam int SEQ_MAX = 6;
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_AUTOSEL, OP_QUERY, OP_PROGRAM, OP_BUF_LOAD, OP_BUF_CONFIRM,
    OP_ABORT_RESET, OP_BYPASS_ENTER, OP_BYPASS_PROG, OP_BYPASS_SERASE, OP_BYPASS_CERASE,
    OP_BYPASS_EXIT, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SUSPEND
  } op_e;
  typedef struct packed {
    logic            wr;
    logic [AW-1:0]   addr;
    logic [7:0]      data;
  } cyc_s;
  typedef struct packed {
    op_e           op;
    logic [AW-1:0] addr;
    logic [7:0]    data;
    logic [7:0]    aux;
  } cmd_s;
endpackage
